// ==== verilog/isr_pkg.sv ====
// constants and types for the interrupt source router
package isr_pkg;
  localparam int ISR_NUM_VEC = 32;
  localparam int ISR_VEC_W = 5;
  localparam int ISR_PRIO_W = 3;
  localparam int ISR_EXC_W = 6;
  localparam int ISR_DMA_W = 16;
  localparam int ISR_CNT_W = 8;
  localparam int ISR_SAVE_CYCLES = 8;
  localparam int ISR_RESTORE_CYCLES = 8;
  localparam logic [5:0] ISR_EXC_BASE = 6'h10;
  localparam logic [2:0] ISR_PRIO_RESET = 3'h0;

  // per-vector source selection codes
  localparam int ISR_SRC_W = 2;
  localparam logic [1:0] ISR_SRC_FIXED = 2'h0;
  localparam logic [1:0] ISR_SRC_DMA = 2'h1;
  localparam logic [1:0] ISR_SRC_FABRIC = 2'h2;
  localparam logic [1:0] ISR_SRC_ILLEGAL = 2'h3;

  // fixed-function line positions on fixed_irq
  localparam int ISR_VEC_LOW_VOLTAGE = 0;
  localparam int ISR_VEC_CACHE_ECC = 1;
  localparam int ISR_VEC_RSVD_LO = 2;
  localparam int ISR_VEC_SLEEP = 3;
  localparam int ISR_VEC_PORT_FIRST = 4;
  localparam int ISR_VEC_PORT_LAST = 12;
  localparam int ISR_VEC_COMPARATORS = 13;
  localparam int ISR_VEC_SWCAP = 14;
  localparam int ISR_VEC_I2C = 15;
  localparam int ISR_VEC_CAN = 16;
  localparam int ISR_VEC_TIMER_FIRST = 17;
  localparam int ISR_VEC_TIMER_LAST = 20;
  localparam int ISR_VEC_USB_FIRST = 21;
  localparam int ISR_VEC_USB_LAST = 25;
  localparam int ISR_VEC_RSVD_HI = 26;
  localparam int ISR_VEC_LCD = 27;
  localparam int ISR_VEC_FILTER = 28;
  localparam int ISR_VEC_DECIMATOR = 29;
  localparam int ISR_VEC_HUB_ERR = 30;
  localparam int ISR_VEC_EEPROM_FAULT = 31;
  // reserved fixed-function positions never raise a request
  localparam logic [31:0] ISR_FIXED_RSVD_MASK = 32'h0400_0004;

  typedef enum logic [3:0] {
    ISR_ST_IDLE = 4'h1,
    ISR_ST_SAVE = 4'h2,
    ISR_ST_RUN = 4'h4,
    ISR_ST_RESTORE = 4'h8
  } isr_state_t;
endpackage

// ==== verilog/isr_prio_pick.sv ====
// priority picker: lowest level wins, lower vector number breaks ties
`timescale 1ns/1ps
module isr_prio_pick
  import isr_pkg::*;
#(
  parameter int NUM_VEC = ISR_NUM_VEC,
  parameter int VEC_W = ISR_VEC_W,
  parameter int PRIO_W = ISR_PRIO_W
) (
  input wire logic [NUM_VEC-1:0] pend,
  input wire logic [NUM_VEC*PRIO_W-1:0] prio,
  output logic win_valid,
  output logic [VEC_W-1:0] win_idx,
  output logic [PRIO_W-1:0] win_prio
);
  always_comb begin
    win_valid = 1'b0;
    win_idx = '0;
    win_prio = '1;
    // scan downward so that on equal level the lower index is kept
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (pend[i] && (!win_valid || prio[i*PRIO_W +: PRIO_W] <= win_prio)) begin
        win_valid = 1'b1;
        win_idx = VEC_W'(i);
        win_prio = prio[i*PRIO_W +: PRIO_W];
      end
    end
  end
endmodule // isr_prio_pick

// ==== verilog/isr_router.sv ====
// interrupt source router, pending latch and exception entry sequencer
//
// Functional notes
// - A pending request is taken straight after the running handler, and a request arriving during state save or restore is taken without a second save.
// - State is saved on entry and restored on exit by hardware, with no instructions run.
// - Among pending requests of equal level the lower vector number is served first.
// - Each vector picks its request from the fixed-function, DMA or fabric line.
// - Vectors 0 to 15 take the low DMA termination group bits 0 to 15, vectors 16 to 31 the high group.
// - The fabric source for vector n is fabric line n, carrying any fabric signal.
// - Any source reaches any vector through the fabric lines, apart from its fixed assignment.
// - Vector n is presented to the core as exception number n plus sixteen.
// - Vectors 0 to 15 carry the listed fixed-function lines, vector 2 reserved.
// - Vectors 16 to 31 carry the listed fixed-function lines, vector 26 reserved.
// - Thirty-two vectors are accepted, each fed from several sources.
// - Eight priority levels exist and a vector's level may change while running.
`timescale 1ns/1ps
module isr_router
  import isr_pkg::*;
#(
  parameter int NUM_VEC = ISR_NUM_VEC,
  parameter int SAVE_CYCLES = ISR_SAVE_CYCLES,
  parameter int RESTORE_CYCLES = ISR_RESTORE_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [NUM_VEC-1:0] fixed_irq,
  input wire logic [ISR_DMA_W-1:0] dma_term_group_lo,
  input wire logic [ISR_DMA_W-1:0] dma_term_group_hi,
  input wire logic [NUM_VEC-1:0] fabric_irq,
  input wire logic cfg_we,
  input wire logic [ISR_VEC_W-1:0] cfg_vec,
  input wire logic [ISR_SRC_W-1:0] cfg_src,
  input wire logic [ISR_PRIO_W-1:0] cfg_prio,
  input wire logic handler_done,
  output logic save_busy,
  output logic restore_busy,
  output logic handler_go,
  output logic [ISR_EXC_W-1:0] exc_num,
  output logic [ISR_PRIO_W-1:0] cur_prio,
  output logic [NUM_VEC-1:0] pend_vec
);
  function automatic logic [ISR_EXC_W-1:0] isr_exc_of(input logic [ISR_VEC_W-1:0] v);
    isr_exc_of = {1'b0, v} + ISR_EXC_BASE;
  endfunction

  // configuration: source select and level per vector
  logic [ISR_SRC_W-1:0] sel_ff [NUM_VEC];
  logic [ISR_SRC_W-1:0] nxt_sel [NUM_VEC];
  logic [NUM_VEC*ISR_PRIO_W-1:0] prio_ff;
  logic [NUM_VEC*ISR_PRIO_W-1:0] nxt_prio;

  always_comb begin
    nxt_sel = sel_ff;
    nxt_prio = prio_ff;
    if (cfg_we && cfg_src != ISR_SRC_ILLEGAL) begin
      nxt_sel[cfg_vec] = cfg_src;
      nxt_prio[cfg_vec*ISR_PRIO_W +: ISR_PRIO_W] = cfg_prio;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_VEC; i++) begin
        sel_ff[i] <= ISR_SRC_FIXED;
      end
      prio_ff <= {NUM_VEC{ISR_PRIO_RESET}};
    end else begin
      sel_ff <= nxt_sel;
      prio_ff <= nxt_prio;
    end
  end

  // source routing
  logic [NUM_VEC-1:0] dma_lines;
  logic [NUM_VEC-1:0] fixed_lines;
  logic [NUM_VEC-1:0] routed_req;

  assign dma_lines = {dma_term_group_hi, dma_term_group_lo};
  assign fixed_lines = fixed_irq & ~ISR_FIXED_RSVD_MASK;

  always_comb begin
    for (int i = 0; i < NUM_VEC; i++) begin
      unique case (sel_ff[i])
        ISR_SRC_FIXED: routed_req[i] = fixed_lines[i];
        ISR_SRC_DMA: routed_req[i] = dma_lines[i];
        // fabric line n may carry any signal, so any source reaches any vector
        ISR_SRC_FABRIC: routed_req[i] = fabric_irq[i];
        default: routed_req[i] = 1'b0;
      endcase
    end
  end

  // pending latch and arbitration
  logic [NUM_VEC-1:0] pend_ff;
  logic [NUM_VEC-1:0] nxt_pend;
  logic [NUM_VEC-1:0] clr_mask;
  logic win_valid;
  logic [ISR_VEC_W-1:0] win_idx;
  logic [ISR_PRIO_W-1:0] win_prio;

  isr_prio_pick #(
    .NUM_VEC(NUM_VEC),
    .VEC_W(ISR_VEC_W),
    .PRIO_W(ISR_PRIO_W)
  ) u_pick (
    .pend(pend_ff),
    .prio(prio_ff),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_prio(win_prio)
  );

  // a new request in the clearing cycle survives
  always_comb begin
    nxt_pend = (pend_ff & ~clr_mask) | routed_req;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // entry and exit sequencer
  isr_state_t state_ff;
  isr_state_t nxt_state;
  logic [ISR_CNT_W-1:0] cnt_ff;
  logic [ISR_CNT_W-1:0] nxt_cnt;
  logic [ISR_VEC_W-1:0] vec_ff;
  logic [ISR_VEC_W-1:0] nxt_vec;
  logic [ISR_PRIO_W-1:0] cur_prio_ff;
  logic [ISR_PRIO_W-1:0] nxt_cur_prio;
  logic [ISR_EXC_W-1:0] exc_ff;
  logic [ISR_EXC_W-1:0] nxt_exc;
  logic go_ff;
  logic nxt_go;
  logic late;

  assign late = win_valid && win_prio < cur_prio_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_vec = vec_ff;
    nxt_cur_prio = cur_prio_ff;
    nxt_exc = exc_ff;
    nxt_go = 1'b0;
    clr_mask = '0;
    unique case (state_ff)
      ISR_ST_IDLE: begin
        if (win_valid) begin
          nxt_state = ISR_ST_SAVE;
          nxt_cnt = '0;
          nxt_vec = win_idx;
          nxt_cur_prio = win_prio;
        end
      end
      ISR_ST_SAVE: begin
        if (late) begin
          nxt_vec = win_idx;
          nxt_cur_prio = win_prio;
        end
        if (cnt_ff == ISR_CNT_W'(SAVE_CYCLES - 1)) begin
          nxt_state = ISR_ST_RUN;
          nxt_go = 1'b1;
          nxt_exc = isr_exc_of(nxt_vec);
          clr_mask[nxt_vec] = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ISR_ST_RUN: begin
        if (handler_done && win_valid) begin
          nxt_go = 1'b1;
          nxt_vec = win_idx;
          nxt_cur_prio = win_prio;
          nxt_exc = isr_exc_of(win_idx);
          clr_mask[win_idx] = 1'b1;
        end else if (handler_done) begin
          nxt_state = ISR_ST_RESTORE;
          nxt_cnt = '0;
        end
      end
      ISR_ST_RESTORE: begin
        if (win_valid) begin
          nxt_state = ISR_ST_RUN;
          nxt_go = 1'b1;
          nxt_vec = win_idx;
          nxt_cur_prio = win_prio;
          nxt_exc = isr_exc_of(win_idx);
          clr_mask[win_idx] = 1'b1;
        end else if (cnt_ff == ISR_CNT_W'(RESTORE_CYCLES - 1)) begin
          nxt_state = ISR_ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      default: nxt_state = ISR_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ISR_ST_IDLE;
      cnt_ff <= '0;
      vec_ff <= '0;
      cur_prio_ff <= ISR_PRIO_RESET;
      exc_ff <= '0;
      go_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      vec_ff <= nxt_vec;
      cur_prio_ff <= nxt_cur_prio;
      exc_ff <= nxt_exc;
      go_ff <= nxt_go;
    end
  end

  assign save_busy = (state_ff == ISR_ST_SAVE);
  assign restore_busy = (state_ff == ISR_ST_RESTORE);
  assign handler_go = go_ff;
  assign exc_num = exc_ff;
  assign cur_prio = cur_prio_ff;
  assign pend_vec = pend_ff;

  // checks
  save_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(save_busy) |-> save_busy[*8] ##1 (handler_go && !save_busy))
    else $error("state save length wrong");
  tail_chain_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_ff == ISR_ST_RUN && handler_done && win_valid) |=>
      (handler_go && !save_busy && !restore_busy))
    else $error("tail chain did not skip save and restore");
  restore_go_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_ff == ISR_ST_RUN && handler_done && !win_valid) |=> restore_busy && !handler_go)
    else $error("exit without restore");
  tie_order_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (win_valid && pend_ff[0] && prio_ff[ISR_PRIO_W-1:0] == win_prio) |-> win_idx == '0)
    else $error("lower vector not first on equal level");
  exc_map_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    handler_go |-> exc_num == {1'b0, vec_ff} + ISR_EXC_BASE)
    else $error("exception number not vector plus sixteen");
  dma_hi_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sel_ff[16] == ISR_SRC_DMA && dma_term_group_hi[0]) |=> pend_ff[16])
    else $error("high dma group bit 0 not on vector 16");
  fabric_route_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sel_ff[5] == ISR_SRC_FABRIC && fabric_irq[5]) |=> pend_ff[5])
    else $error("fabric line 5 not on vector 5");
  rsvd_fixed_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sel_ff[2] == ISR_SRC_FIXED) |-> !routed_req[2])
    else $error("reserved fixed line raised a request");
  prio_update_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cfg_we && cfg_src != ISR_SRC_ILLEGAL) |=>
      prio_ff[$past(cfg_vec)*ISR_PRIO_W +: ISR_PRIO_W] == $past(cfg_prio))
    else $error("priority level not updated");
  pend_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (routed_req != '0) |=> ((pend_ff & $past(routed_req)) == $past(routed_req)))
    else $error("request lost in clearing cycle");

  tail_chain_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    state_ff == ISR_ST_RUN && handler_done && win_valid);
  late_arrival_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    save_busy && late);
  restore_done_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    restore_busy ##1 state_ff == ISR_ST_IDLE);
  restore_abort_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    restore_busy && win_valid);
endmodule // isr_router

// ==== verification/isr_core_model.sv ====
// behavioural core entry model: runs a handler for run_len plus one cycles, then signals exit
`timescale 1ns/1ps
module isr_core_model
  import isr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic handler_go,
  input wire logic [ISR_CNT_W-1:0] run_len,
  output logic handler_done
);
  logic [ISR_CNT_W-1:0] left_ff;
  logic busy_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      left_ff <= '0;
      busy_ff <= 1'b0;
      handler_done <= 1'b0;
    end else begin
      handler_done <= 1'b0;
      if (handler_go) begin
        busy_ff <= 1'b1;
        left_ff <= run_len;
      end else if (busy_ff) begin
        if (left_ff == '0) begin
          handler_done <= 1'b1;
          busy_ff <= 1'b0;
        end else begin
          left_ff <= left_ff - 8'h01;
        end
      end
    end
  end
endmodule // isr_core_model

// ==== verification/interrupt_source_router_test.sv ====
// self-checking bench for the interrupt source router
`timescale 1ns/1ps
module interrupt_source_router_test;
  import isr_pkg::*;
  typedef struct packed {
    logic [4:0] vec;
    logic [1:0] src;
    logic [1:0] kind;
    logic hit;
  } isr_row_t;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] fixed_irq = '0;
  logic [15:0] dma_lo = '0;
  logic [15:0] dma_hi = '0;
  logic [31:0] fabric_irq = '0;
  logic cfg_we = 1'b0;
  logic [4:0] cfg_vec = '0;
  logic [1:0] cfg_src = '0;
  logic [2:0] cfg_prio = '0;
  logic [7:0] run_len = 8'h03;
  logic handler_done, save_busy, restore_busy, handler_go;
  logic [5:0] exc_num;
  logic [2:0] cur_prio;
  logic [31:0] pend_vec;
  logic restore_seen = 1'b0;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  // vector, selected source, line raised, request expected
  isr_row_t rows [13] = '{
    '{5'h00, ISR_SRC_FIXED, ISR_SRC_FIXED, 1'b1},
    '{5'h02, ISR_SRC_FIXED, ISR_SRC_FIXED, 1'b0},
    '{5'h1A, ISR_SRC_FIXED, ISR_SRC_FIXED, 1'b0},
    '{5'h1F, ISR_SRC_FIXED, ISR_SRC_FIXED, 1'b1},
    '{5'h0F, ISR_SRC_DMA, ISR_SRC_DMA, 1'b1},
    '{5'h10, ISR_SRC_DMA, ISR_SRC_DMA, 1'b1},
    '{5'h1F, ISR_SRC_DMA, ISR_SRC_DMA, 1'b1},
    '{5'h02, ISR_SRC_DMA, ISR_SRC_DMA, 1'b1},
    '{5'h05, ISR_SRC_FABRIC, ISR_SRC_FABRIC, 1'b1},
    '{5'h1A, ISR_SRC_FABRIC, ISR_SRC_FABRIC, 1'b1},
    '{5'h09, ISR_SRC_FABRIC, ISR_SRC_FIXED, 1'b0},
    '{5'h14, ISR_SRC_DMA, ISR_SRC_FABRIC, 1'b0},
    '{5'h0C, ISR_SRC_FIXED, ISR_SRC_DMA, 1'b0}
  };

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (restore_busy === 1'b1) restore_seen <= 1'b1;

  isr_router DUT (.core_clk(core_clk), .reset_n(reset_n), .fixed_irq(fixed_irq),
    .dma_term_group_lo(dma_lo), .dma_term_group_hi(dma_hi), .fabric_irq(fabric_irq),
    .cfg_we(cfg_we), .cfg_vec(cfg_vec), .cfg_src(cfg_src), .cfg_prio(cfg_prio),
    .handler_done(handler_done), .save_busy(save_busy), .restore_busy(restore_busy),
    .handler_go(handler_go), .exc_num(exc_num), .cur_prio(cur_prio), .pend_vec(pend_vec));
  isr_core_model core (.core_clk(core_clk), .reset_n(reset_n), .handler_go(handler_go),
    .run_len(run_len), .handler_done(handler_done));

  task automatic complete_run;
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cfg_write(input logic [4:0] v, input logic [1:0] s, input logic [2:0] p);
    cfg_we = 1'b1;
    cfg_vec = v;
    cfg_src = s;
    cfg_prio = p;
    @(negedge core_clk);
    cfg_we = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic pulse_line(input logic [1:0] kind, input logic [4:0] v);
    case (kind)
      ISR_SRC_FIXED: fixed_irq[v] = 1'b1;
      ISR_SRC_DMA: if (v < 5'h10) dma_lo[v[3:0]] = 1'b1; else dma_hi[v[3:0]] = 1'b1;
      default: fabric_irq[v] = 1'b1;
    endcase
    @(negedge core_clk);
    fixed_irq = '0;
    dma_lo = '0;
    dma_hi = '0;
    fabric_irq = '0;
  endtask

  task automatic expect_go(input logic [5:0] e, input logic [2:0] p);
    int w;
    w = 0;
    while (handler_go !== 1'b1 && w < 100) begin
      @(negedge core_clk);
      w++;
    end
    check("handler_go", 32'h1, 32'(handler_go));
    check("exc_num", 32'(e), 32'(exc_num));
    check("cur_prio", 32'(p), 32'(cur_prio));
    @(negedge core_clk);
  endtask

  // waits for the busy flag, then counts its high cycles
  task automatic count_high(input bit rst_sel, output int cnt);
    int w;
    w = 0;
    cnt = 0;
    while ((rst_sel ? restore_busy : save_busy) !== 1'b1 && w < 60) begin
      @(negedge core_clk);
      w++;
    end
    while ((rst_sel ? restore_busy : save_busy) === 1'b1 && cnt < 60) begin
      @(negedge core_clk);
      cnt++;
    end
    check("busy_wait", 32'h0, 32'(w >= 60 || cnt >= 60));
  endtask

  task automatic pair_test(input logic [4:0] a, input logic [2:0] pa, input logic [4:0] b,
      input logic [2:0] pb, input logic [5:0] e1, input logic [2:0] q1,
      input logic [5:0] e2, input logic [2:0] q2);
    cfg_write(a, ISR_SRC_FIXED, pa);
    cfg_write(b, ISR_SRC_FIXED, pb);
    fixed_irq[a] = 1'b1;
    fixed_irq[b] = 1'b1;
    @(negedge core_clk);
    fixed_irq = '0;
    restore_seen = 1'b0;
    expect_go(e1, q1);
    expect_go(e2, q2);
    check("restore_between", 32'h0, 32'(restore_seen));
    count_high(1'b1, n);
  endtask

  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (2) @(negedge core_clk);
    check("pend_vec", 32'h0, pend_vec);
    check("outputs", 32'h0, {20'h0, save_busy, restore_busy, handler_go, exc_num, cur_prio});
    reset_n = 1'b1;
    foreach (rows[i]) begin
      cfg_write(rows[i].vec, rows[i].src, 3'h0);
      pulse_line(rows[i].kind, rows[i].vec);
      if (rows[i].hit) begin
        expect_go(6'({1'b0, rows[i].vec}) + ISR_EXC_BASE, 3'h0);
        count_high(1'b1, n);
      end else begin
        check("pend_bit", 32'h0, 32'(pend_vec[rows[i].vec]));
      end
    end
    // second reset: every vector back on its fixed line
    reset_n = 1'b0;
    @(negedge core_clk);
    reset_n = 1'b1;
    pulse_line(ISR_SRC_FIXED, 5'h05);
    expect_go(6'h15, 3'h0);
    count_high(1'b1, n);
    run_len = 8'h14;
    pulse_line(ISR_SRC_FIXED, 5'h03);
    count_high(1'b0, n);
    check("save_cycles", 32'(ISR_SAVE_CYCLES), 32'(n));
    expect_go(6'h13, 3'h0);
    count_high(1'b1, n);
    check("restore_cycles", 32'(ISR_RESTORE_CYCLES), 32'(n));
    cfg_write(5'h06, ISR_SRC_ILLEGAL, 3'h7);
    pulse_line(ISR_SRC_FIXED, 5'h06);
    expect_go(6'h16, 3'h0);
    count_high(1'b1, n);
    run_len = 8'h00;
    pair_test(5'h09, 3'h2, 5'h07, 3'h2, 6'h17, 3'h2, 6'h19, 3'h2);
    pair_test(5'h04, 3'h5, 5'h1E, 3'h1, 6'h2E, 3'h1, 6'h14, 3'h5);
    pair_test(5'h04, 3'h5, 5'h1E, 3'h7, 6'h14, 3'h5, 6'h2E, 3'h7);
    // late arrival during save: the more urgent vector overtakes, then tail chain
    cfg_write(5'h0B, ISR_SRC_FIXED, 3'h5);
    cfg_write(5'h11, ISR_SRC_FIXED, 3'h1);
    pulse_line(ISR_SRC_FIXED, 5'h0B);
    repeat (2) @(negedge core_clk);
    pulse_line(ISR_SRC_FIXED, 5'h11);
    expect_go(6'h21, 3'h1);
    expect_go(6'h1B, 3'h5);
    count_high(1'b1, n);
    // request during restore: restore abandoned, no second save
    pulse_line(ISR_SRC_FIXED, 5'h08);
    expect_go(6'h18, 3'h0);
    n = 0;
    while (restore_busy !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    pulse_line(ISR_SRC_FIXED, 5'h0E);
    @(negedge core_clk);
    check("abort_go", 32'h1, 32'(handler_go));
    check("abort_exc", 32'h1E, 32'(exc_num));
    check("abort_save", 32'h0, 32'(save_busy));
    count_high(1'b1, n);
    complete_run();
  end
endmodule // interrupt_source_router_test
